// file: hw/scan_pkg.sv
// constants, chain map and state type for the boundary scan test logic
// assumes a 284-cell chain, cell 0 next to the serial output
`default_nettype none
package scan_pkg;
  localparam int          CHAIN_LEN    = 284;
  localparam int          IR_W         = 3;
  localparam int          SYNC_STAGES  = 2;
  localparam logic [2:0]  IR_EXTEST    = 3'h0;
  localparam logic [2:0]  IR_PRIV_ONE  = 3'h1;  // private_code_one
  localparam logic [2:0]  IR_SAMPLE    = 3'h2;
  localparam logic [2:0]  IR_PRIV_MWQ  = 3'h3;  // private_master_write_queue_test
  localparam logic [2:0]  IR_PRIV_MRQ  = 3'h4;  // private_master_read_queue_test
  localparam logic [2:0]  IR_PRIV_SEG  = 3'h5;  // private_segment_queue_test
  localparam logic [2:0]  IR_PRIV_RSM  = 3'h6;  // private_reassembly_queue_test
  localparam logic [2:0]  IR_BYPASS    = 3'h7;
  localparam logic [2:0]  IR_CAPTURE   = 3'h1;
  localparam logic [8:0]  NO_CTRL      = 9'h1FF;
  localparam int          BI_STATE_CELL = 59;   // always driven, no control cell

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

  function automatic logic is_ctrl(input int i);
    case (i)
      32, 51, 54, 97, 101, 108, 111, 114, 137, 154, 157, 170, 172, 175, 178, 184, 187, 262, 283:
        return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // controlling cell of each output cell; open-drain cells govern themselves
  function automatic logic [8:0] ctrl_of(input int i);
    if ((i <= 31 && i % 2 == 0) || i == 33) return 9'd32;
    if (i == 43 || i == 47 || i == 49 || i == 52) return 9'd51;
    if (i == 45) return 9'd283;
    if (i == 55) return 9'd54;
    if (i == 58 || i == 100 || i == 161) return 9'(i);
    if (i == 77 || i == 95 || i == 118 || i == 138) return 9'd137;
    if (i >= 61 && i <= 96 && i % 2 == 1) return 9'd154;
    if (((i >= 120 && i <= 134) || (i >= 140 && i <= 152)) && i % 2 == 0) return 9'd154;
    if (i == 155) return 9'd154;
    if (i == 98) return 9'd97;
    if (i == 102) return 9'd101;
    if (i == 104 || i == 106 || i == 109) return 9'd108;
    if (i == 112) return 9'd111;
    if (i == 115) return 9'd114;
    if (i == 158) return 9'd157;
    if ((i >= 162 && i <= 169) || i == 171) return 9'd170;
    if (i == 173) return 9'd172;
    if (i == 176) return 9'd175;
    if (i == 179) return 9'd178;
    if (i == 185) return 9'd184;
    if (i == 188) return 9'd187;
    if ((i >= 200 && i <= 260 && i % 2 == 0) || i == 263) return 9'd262;
    if ((i >= 266 && i <= 277) || (i >= 279 && i <= 282)) return 9'd283;
    return NO_CTRL;
  endfunction

  function automatic logic is_out(input int i);
    return (ctrl_of(i) != NO_CTRL) || (i == BI_STATE_CELL);
  endfunction

  function automatic logic [CHAIN_LEN-1:0] ctrl_mask();
    logic [CHAIN_LEN-1:0] m;
    m = '0;
    for (int i = 0; i < CHAIN_LEN; i++) m[i] = is_ctrl(i);
    return m;
  endfunction

  localparam logic [CHAIN_LEN-1:0] CTRL_MASK = ctrl_mask();
endpackage
`default_nettype wire

// file: hw/scan_tap.sv
// boundary scan test access logic: tap controller, instruction, bypass and boundary chain
// assumes the tester drives tck_i, tms_i, tdi_i, trst_n_i; pads resolved outside from pad_oe_o
`default_nettype none
module scan_tap (
  input  wire  logic                           mclk_i,
  input  wire  logic                           srst_i,
  input  wire  logic                           tck_i,
  input  wire  logic                           trst_n_i,
  input  wire  logic                           tms_i,
  input  wire  logic                           tdi_i,
  input  wire  logic [scan_pkg::CHAIN_LEN-1:0] pad_in_i,
  input  wire  logic [scan_pkg::CHAIN_LEN-1:0] func_out_i,
  output var   logic                           tdo_o,
  output var   logic                           tdo_oe_o,
  output var   logic [scan_pkg::CHAIN_LEN-1:0] pad_out_o,
  output var   logic [scan_pkg::CHAIN_LEN-1:0] pad_oe_o,
  output var   logic                           test_mode_o
);
  localparam int N = scan_pkg::CHAIN_LEN;

  typedef struct packed {
    scan_pkg::tap_state_t          st;
    logic [scan_pkg::IR_W-1:0]     ir;
    logic [scan_pkg::IR_W-1:0]     ir_sh;
    logic                          byp;
    logic                          priv;
    logic                          ext;
    logic [N-1:0]                  sh;
    logic [N-1:0]                  upd;
  } tap_reg_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } out_reg_t;

  typedef struct packed {
    logic [scan_pkg::SYNC_STAGES-1:0] sync;
  } sys_reg_t;

  localparam tap_reg_t TAP_RST = '{st: scan_pkg::TLR, ir: scan_pkg::IR_BYPASS, ir_sh: '0,
                                   byp: 1'b0, priv: 1'b0, ext: 1'b0, sh: '0, upd: scan_pkg::CTRL_MASK};

  tap_reg_t tap_q;
  tap_reg_t tap_d;
  out_reg_t out_q;
  out_reg_t out_d;
  sys_reg_t sys_q;
  sys_reg_t sys_d;
  logic     sel_bsr;
  logic     sel_byp;
  logic     extest;
  logic     tdo_src;
  logic [N-1:0] val;

  assign sel_bsr = (tap_q.ir == scan_pkg::IR_EXTEST) || (tap_q.ir == scan_pkg::IR_SAMPLE);
  assign sel_byp = (tap_q.ir == scan_pkg::IR_BYPASS);
  assign extest  = (tap_q.ir == scan_pkg::IR_EXTEST);

  function automatic scan_pkg::tap_state_t next_st(input scan_pkg::tap_state_t s, input logic m);
    unique case (s)
      scan_pkg::TLR:      return m ? scan_pkg::TLR      : scan_pkg::RTI;
      scan_pkg::RTI:      return m ? scan_pkg::SEL_DR   : scan_pkg::RTI;
      scan_pkg::SEL_DR:   return m ? scan_pkg::SEL_IR   : scan_pkg::CAP_DR;
      scan_pkg::CAP_DR:   return m ? scan_pkg::EXIT1_DR : scan_pkg::SHIFT_DR;
      scan_pkg::SHIFT_DR: return m ? scan_pkg::EXIT1_DR : scan_pkg::SHIFT_DR;
      scan_pkg::EXIT1_DR: return m ? scan_pkg::UPD_DR   : scan_pkg::PAUSE_DR;
      scan_pkg::PAUSE_DR: return m ? scan_pkg::EXIT2_DR : scan_pkg::PAUSE_DR;
      scan_pkg::EXIT2_DR: return m ? scan_pkg::UPD_DR   : scan_pkg::SHIFT_DR;
      scan_pkg::UPD_DR:   return m ? scan_pkg::SEL_DR   : scan_pkg::RTI;
      scan_pkg::SEL_IR:   return m ? scan_pkg::TLR      : scan_pkg::CAP_IR;
      scan_pkg::CAP_IR:   return m ? scan_pkg::EXIT1_IR : scan_pkg::SHIFT_IR;
      scan_pkg::SHIFT_IR: return m ? scan_pkg::EXIT1_IR : scan_pkg::SHIFT_IR;
      scan_pkg::EXIT1_IR: return m ? scan_pkg::UPD_IR   : scan_pkg::PAUSE_IR;
      scan_pkg::PAUSE_IR: return m ? scan_pkg::EXIT2_IR : scan_pkg::PAUSE_IR;
      scan_pkg::EXIT2_IR: return m ? scan_pkg::UPD_IR   : scan_pkg::SHIFT_IR;
      scan_pkg::UPD_IR:   return m ? scan_pkg::SEL_DR   : scan_pkg::RTI;
    endcase
  endfunction

  // rising-edge side of the test clock; purely static, so a halted clock loses nothing
  always_comb begin
    tap_d    = tap_q;
    tap_d.st = next_st(tap_q.st, tms_i);
    unique case (tap_q.st)
      scan_pkg::TLR: begin
        tap_d.ir  = scan_pkg::IR_BYPASS;
        tap_d.upd = scan_pkg::CTRL_MASK;
      end
      scan_pkg::CAP_IR: tap_d.ir_sh = scan_pkg::IR_CAPTURE;
      scan_pkg::SHIFT_IR: tap_d.ir_sh = {tdi_i, tap_q.ir_sh[scan_pkg::IR_W-1:1]};
      scan_pkg::UPD_IR: tap_d.ir = tap_q.ir_sh;
      scan_pkg::CAP_DR: begin
        if (sel_bsr) begin
          for (int i = 0; i < N; i++) begin
            // output and control cells see the system side, input cells the pin
            tap_d.sh[i] = (scan_pkg::is_out(i) || scan_pkg::is_ctrl(i)) ? func_out_i[i] : pad_in_i[i];
          end
        end else if (sel_byp) begin
          tap_d.byp = 1'b0;
        end else begin
          tap_d.priv = 1'b0;
        end
      end
      scan_pkg::SHIFT_DR: begin
        if (sel_bsr) begin
          tap_d.sh = {tdi_i, tap_q.sh[N-1:1]};
        end else if (sel_byp) begin
          tap_d.byp = tdi_i;
        end else begin
          tap_d.priv = tdi_i;
        end
      end
      scan_pkg::UPD_DR: begin
        if (sel_bsr) begin
          tap_d.upd = tap_q.sh;
        end
      end
      default: ;
    endcase
    // registered decode: a multi-bit compare could glitch into the crossing
    tap_d.ext = (tap_d.ir == scan_pkg::IR_EXTEST);
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tap_q <= TAP_RST;
    end else begin
      tap_q <= tap_d;
    end
  end

  always_comb begin
    if (tap_q.st == scan_pkg::SHIFT_IR) begin
      tdo_src = tap_q.ir_sh[0];
    end else if (sel_bsr) begin
      tdo_src = tap_q.sh[0];
    end else if (sel_byp) begin
      tdo_src = tap_q.byp;
    end else begin
      tdo_src = tap_q.priv;
    end
    out_d.tdo    = tdo_src;
    out_d.tdo_oe = (tap_q.st == scan_pkg::SHIFT_IR) || (tap_q.st == scan_pkg::SHIFT_DR);
  end

  // serial output changes on the falling edge, half a clock after the shift
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign tdo_o    = out_q.tdo;
  assign tdo_oe_o = out_q.tdo_oe;

  // pad muxes stay combinational: a flop here would add a cycle to every system output
  always_comb begin
    for (int i = 0; i < N; i++) begin
      val[i] = extest ? tap_q.upd[i] : func_out_i[i];
    end
    for (int i = 0; i < N; i++) begin
      pad_out_o[i] = 1'b0;
      pad_oe_o[i]  = 1'b0;
      if (scan_pkg::is_out(i)) begin
        pad_out_o[i] = val[i];
        if (i == scan_pkg::BI_STATE_CELL) begin
          pad_oe_o[i] = 1'b1;
        end else begin
          // enables are active low at the cell, so 1 keeps the pad quiet
          pad_oe_o[i] = ~val[scan_pkg::ctrl_of(i)];
        end
      end
    end
  end

  // extest level handed to the system clock so the core can hold off
  always_comb begin
    sys_d.sync = {sys_q.sync[scan_pkg::SYNC_STAGES-2:0], tap_q.ext};
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign test_mode_o = sys_q.sync[scan_pkg::SYNC_STAGES-1];

  a_ir_reset_load: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::TLR |=> tap_q.ir == 3'h7) else $error("reset did not load bypass code");

  a_ir_capture_pat: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::CAP_IR |=> tap_q.ir_sh == 3'h1) else $error("capture-ir pattern wrong");

  a_ir_lsb_first: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::SHIFT_IR |=> tap_q.ir_sh[2] == $past(tdi_i) && tap_q.ir_sh[0] == $past(tap_q.ir_sh[1]))
    else $error("instruction shift order wrong");

  a_bypass_one_bit: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::SHIFT_DR && tap_q.ir == 3'h7) ##1 (tap_q.st == scan_pkg::SHIFT_DR)
    |-> tap_q.byp == $past(tdi_i)) else $error("bypass stage not one bit");

  a_chain_shift_dir: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::SHIFT_DR && tap_q.ir == 3'h2)
    |=> tap_q.sh[283] == $past(tdi_i) && tap_q.sh[0] == $past(tap_q.sh[1])) else $error("chain shifts wrong way");

  a_input_capture: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::CAP_DR && tap_q.ir == 3'h2) |=> tap_q.sh[1] == $past(pad_in_i[1]))
    else $error("input cell missed pin value");

  a_tlr_ctrl_high: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::TLR |=> tap_q.upd[32] && tap_q.upd[154] && tap_q.upd[283])
    else $error("control update stage not set");

  a_extest_ctrl_off: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.ir == 3'h0 && tap_q.upd[32]) |-> !pad_oe_o[0] && !pad_oe_o[33]) else $error("disabled output drives");

  a_extest_value: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.ir == 3'h0 |-> pad_out_o[45] == tap_q.upd[45] && pad_oe_o[45] == !tap_q.upd[283])
    else $error("extest value or enable wrong");

  a_tms_to_reset: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tms_i [*5] |=> tap_q.st == scan_pkg::TLR) else $error("five tms highs did not reset");

  a_ir_update_load: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::UPD_IR |=> tap_q.ir == $past(tap_q.ir_sh))
    else $error("instruction not taken at update");

  a_ir_hold_idle: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::RTI |=> tap_q.ir == $past(tap_q.ir))
    else $error("instruction changed while idle");

  a_byp_capture_zero: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::CAP_DR && tap_q.ir == scan_pkg::IR_BYPASS) |=> !tap_q.byp)
    else $error("bypass stage did not capture zero");

  a_priv_capture_zero: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::CAP_DR && tap_q.ir == scan_pkg::IR_PRIV_ONE) |=> !tap_q.priv)
    else $error("private stage did not capture zero");

  a_priv_chain_idle: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::SHIFT_DR && tap_q.ir == scan_pkg::IR_PRIV_MWQ) |=> tap_q.sh == $past(tap_q.sh))
    else $error("private code moved the chain");

  a_byp_chain_idle: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::SHIFT_DR && tap_q.ir == scan_pkg::IR_BYPASS) |=> tap_q.sh == $past(tap_q.sh))
    else $error("bypass moved the chain");

  a_extest_shift_in: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::SHIFT_DR && tap_q.ir == scan_pkg::IR_EXTEST) |=> tap_q.sh[283] == $past(tdi_i))
    else $error("extest does not shift the chain");

  a_update_preload: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::UPD_DR && tap_q.ir == scan_pkg::IR_SAMPLE) |=> tap_q.upd == $past(tap_q.sh))
    else $error("preload not taken at update");

  a_update_held: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::UPD_DR && tap_q.ir == scan_pkg::IR_BYPASS) |=> tap_q.upd == $past(tap_q.upd))
    else $error("bypass update touched the chain");

  a_ctrl_capture: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::CAP_DR && tap_q.ir == scan_pkg::IR_SAMPLE) |=> tap_q.sh[32] == $past(func_out_i[32]))
    else $error("control cell missed system enable");

  a_out_capture: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::CAP_DR && tap_q.ir == scan_pkg::IR_EXTEST) |=> tap_q.sh[45] == $past(func_out_i[45]))
    else $error("output cell missed system value");

  a_far_input_cap: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::CAP_DR && tap_q.ir == scan_pkg::IR_EXTEST) |=> tap_q.sh[265] == $past(pad_in_i[265]))
    else $error("far input cell missed pin value");

  a_normal_value: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.ir != scan_pkg::IR_EXTEST |-> pad_out_o[0] == func_out_i[0] && pad_out_o[171] == func_out_i[171])
    else $error("system value not passed to pad");

  a_normal_enable: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.ir != scan_pkg::IR_EXTEST |-> pad_oe_o[0] == !func_out_i[32] && pad_oe_o[55] == !func_out_i[54])
    else $error("system enable not passed to pad");

  a_host_enable: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.ir == scan_pkg::IR_EXTEST |-> pad_oe_o[61] == !tap_q.upd[154] && pad_oe_o[77] == !tap_q.upd[137])
    else $error("host enables on wrong control cell");

  a_txd_enable: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.ir == scan_pkg::IR_EXTEST |-> pad_oe_o[162] == !tap_q.upd[170] && pad_oe_o[171] == !tap_q.upd[170])
    else $error("transmit enables on wrong control cell");

  a_open_drain: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    pad_oe_o[58] == !pad_out_o[58] && pad_oe_o[100] == !pad_out_o[100] && pad_oe_o[161] == !pad_out_o[161])
    else $error("open-drain cell drives a high");

  a_local_address_bus_enable: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.ir == scan_pkg::IR_EXTEST |-> pad_oe_o[2] == !tap_q.upd[32] && !pad_oe_o[34])
    else $error("local address enable wrong");

  a_local_data_bus_enable: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.ir == scan_pkg::IR_EXTEST |-> pad_oe_o[200] == !tap_q.upd[262] && pad_oe_o[263] == !tap_q.upd[262])
    else $error("local data enable wrong");

  a_bi_state_on: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    pad_oe_o[59])
    else $error("bi-state output not driven");

  a_input_quiet: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    !pad_oe_o[1] && !pad_oe_o[265] && !pad_out_o[1])
    else $error("input cell drives its pad");

  a_tdo_enable: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tdo_oe_o == (tap_q.st == scan_pkg::SHIFT_IR || tap_q.st == scan_pkg::SHIFT_DR))
    else $error("serial output enable outside shift");

  a_tdo_ir_bit: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::SHIFT_IR |-> tdo_o == tap_q.ir_sh[0])
    else $error("serial output not instruction bit 0");

  a_tdo_bypass: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::SHIFT_DR && tap_q.ir == scan_pkg::IR_BYPASS) |-> tdo_o == tap_q.byp)
    else $error("serial output not bypass stage");

  a_tdo_chain: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::SHIFT_DR && tap_q.ir == scan_pkg::IR_SAMPLE) |-> tdo_o == tap_q.sh[0])
    else $error("serial output not cell 0");

  a_tlr_sticky: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::TLR && tms_i) |=> tap_q.st == scan_pkg::TLR)
    else $error("reset state left with mode high");

  a_tlr_exit: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (tap_q.st == scan_pkg::TLR && !tms_i) |=> tap_q.st == scan_pkg::RTI)
    else $error("reset state not left to idle");

  a_ctrl_reset_all: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::TLR |=> tap_q.upd == scan_pkg::CTRL_MASK)
    else $error("update stages not at reset pattern");

  a_ir_exit_hold: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::EXIT1_IR |=> tap_q.ir_sh == $past(tap_q.ir_sh))
    else $error("instruction stage moved outside shift");

  a_chain_exit_hold: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_q.st == scan_pkg::EXIT1_DR |=> tap_q.sh == $past(tap_q.sh))
    else $error("chain moved outside shift");

  a_mode_sync: assert property (@(posedge mclk_i) disable iff (srst_i)
    test_mode_o == $past(sys_q.sync[0]))
    else $error("test mode skipped a sync stage");
endmodule  // scan_tap
`default_nettype wire

// file: dv/tap_tester.sv
// board tester model: drives the test pins, reads serial out
// assumes the bench calls step and pulse_reset; tck rests low between scans
`default_nettype none
module tap_tester (
  input  wire logic tdo_i,
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  output var  logic trst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b0;
  end

  // one 125 ns tck period; mode and data set while low, serial out taken before the rise
  task automatic step(input logic ms, input logic di, output logic do_s);
    tms_o = ms;
    tdi_o = di;
    #31;
    do_s = tdo_i;
    tck_o = 1'b1;
    #62;
    tck_o = 1'b0;
    #32;
  endtask

  // held two tck periods, beyond the one-period minimum
  task automatic pulse_reset();
    trst_n_o = 1'b0;
    #250;
    trst_n_o = 1'b1;
    #125;
  endtask
endmodule  // tap_tester
`default_nettype wire

// file: dv/boundary_scan_tap_test.sv
// self-checking bench for scan_tap with a queue model of the one-bit scan paths
// assumes scan_pkg and tap_tester are compiled first
`default_nettype none
module boundary_scan_tap_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = scan_pkg::CHAIN_LEN;
  logic         mclk_i, srst_i, tck, tms, tdi, trst_n, tdo, tdo_oe, test_mode, b;
  logic [N-1:0] pad_in, func_out, pad_out, pad_oe, pat, bp, dout, src;
  logic [2:0]   got, code;
  int           error_cnt, n_checks, cyc, seed;
  logic         q[$];
  int           oc[9] = '{0, 45, 162, 171, 61, 77, 58, 200, 43};
  int           cc[9] = '{32, 283, 170, 170, 154, 137, 58, 262, 51};
  int           ic[5] = '{1, 35, 117, 199, 265};

  scan_tap dut (.mclk_i(mclk_i), .srst_i(srst_i), .tck_i(tck), .trst_n_i(trst_n), .tms_i(tms),
    .tdi_i(tdi), .pad_in_i(pad_in), .func_out_i(func_out), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .test_mode_o(test_mode));
  tap_tester tester (.tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic mv(input logic ms);
    tester.step(ms, 1'b0, b);
  endtask

  // from idle into shift-ir and back to idle
  task automatic load_ir(input logic [2:0] c);
    mv(1'b1);
    mv(1'b1);
    mv(1'b0);
    mv(1'b0);
    for (int k = 0; k < 3; k++) tester.step(k == 2, c[k], got[k]);
    mv(1'b1);
    mv(1'b0);
    chk("tdo_oe_idle", 1'b0, tdo_oe);
  endtask

  task automatic scan_dr(input logic [N-1:0] din, input int len);
    mv(1'b1);
    mv(1'b0);
    mv(1'b0);
    for (int k = 0; k < len; k++) begin
      if (k == 140) begin
        #3000;  // tck parked mid-shift
        chk("tdo_oe_shift", 1'b1, tdo_oe);
      end
      tester.step(k == len - 1, din[k], dout[k]);
    end
    mv(1'b1);
    mv(1'b0);
  endtask

  task automatic check_delay();
    for (int i = 0; i < 8; i++) bp[i] = 1'($random(seed));
    q = '{1'b0};
    scan_dr(bp, 8);
    for (int k = 0; k < 8; k++) begin
      q.push_back(bp[k]);
      chk("one_bit_path", q.pop_front(), dout[k]);
    end
  endtask

  task automatic pads_check(input logic ext);
    src = ext ? pat : func_out;
    for (int i = 0; i < 9; i++) begin
      chk("pad_out", src[oc[i]], pad_out[oc[i]]);
      chk("pad_oe", !src[cc[i]], pad_oe[oc[i]]);
    end
    chk("pad_oe_59", 1'b1, pad_oe[59]);
  endtask

  task automatic set_io();
    @(negedge mclk_i);
    for (int i = 0; i < N; i++) begin
      pad_in[i] = 1'($random(seed));
      func_out[i] = 1'($random(seed));
      pat[i] = 1'($random(seed));
    end
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // whole run is near 2050 mclk cycles; the ceiling leaves wide margin
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    seed = 32'h121C;
    srst_i = 1'b1;
    pad_in = '0;
    func_out = '0;
    pat = '0;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    srst_i = 1'b0;
    tester.pulse_reset();
    mv(1'b0);
    check_delay();
    // sample/preload comes before extest so extest shows the preloaded pattern
    for (int k = 0; k < 8; k++) begin
      code = 3'(k) ^ 3'h2;
      load_ir(code);
      chk("capture_ir", 3'h1, got);
      repeat (4) @(negedge mclk_i);
      chk("test_mode", code == 3'h0, test_mode);
      if (code == 3'h0 || code == 3'h2) begin
        pads_check(code == 3'h0);
        set_io();
        scan_dr(pat, N);
        foreach (ic[i]) chk("cap_in", pad_in[ic[i]], dout[ic[i]]);
        foreach (oc[i]) chk("cap_out", func_out[oc[i]], dout[oc[i]]);
        foreach (cc[i]) chk("cap_ctrl", func_out[cc[i]], dout[cc[i]]);
        pads_check(code == 3'h0);
      end
      else begin
        check_delay();
      end
    end
    tester.pulse_reset();
    mv(1'b0);
    load_ir(3'h0);
    foreach (oc[i]) if (oc[i] != 58) chk("oe_after_reset", 1'b0, pad_oe[oc[i]]);
    report_and_stop();
  end
endmodule  // boundary_scan_tap_test
`default_nettype wire
